// ==== hdl/osccu_halt_keeper.sv ====
// Sticky halt flag kept on the power-on reset only.
// Assumes por is asynchronous, active high, and outlives the system reset.
`timescale 1ns/1ps

module osccu_halt_keeper (
  input wire logic clk,
  input wire logic por,
  input wire logic dead_cfg,
  output logic halted
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic halted;
  } osccu_halt_state_t;

  osccu_halt_state_t s_q;
  osccu_halt_state_t s_d;

  // System reset cannot clear it: only a power cycle revives the part
  always_comb begin
    s_d = s_q;
    if (dead_cfg) begin
      s_d.halted = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign halted = s_q.halted;

  a_halt_sticky: assert property (
    @(posedge clk) disable iff (por) s_q.halted |=> s_q.halted)
    else $error("halt flag dropped without power-on reset");

endmodule

// ==== hdl/osccu_pkg.sv ====
// Constants, register layout and carrier types of the oscillator control unit.
// Assumes one 100 MHz system clock and a 32-bit Avalon-MM register bus.
package osccu_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ----------------------------------------
  // Register map, index times four gives the byte address
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OSC_CTRL_IDX = 16'h0F86;
  localparam logic [ADDR_W-1:0] OSC_STAT_IDX = 16'h0F87;
  localparam logic [ADDR_W-1:0] OSC_CTRL_ADDR = 16'h3E18;
  localparam logic [ADDR_W-1:0] OSC_STAT_ADDR = 16'h3E1C;

  // ----------------------------------------
  // Unlock keys and reset value
  // ----------------------------------------
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'hE7;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h18;
  localparam logic [7:0] OSC_CTRL_RESET = 8'hA0;

  // ----------------------------------------
  // Field positions of the control register
  // ----------------------------------------
  localparam int BIT_INT_OSC_EN = 7;
  localparam int BIT_XTAL_EN = 6;
  localparam int BIT_WDT_OSC_EN = 5;
  localparam int BIT_SYS_FAIL_EN = 4;
  localparam int BIT_WDT_FAIL_EN = 3;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;

  // ----------------------------------------
  // Field positions of the status register
  // ----------------------------------------
  localparam int STAT_LOCK_LSB = 0;
  localparam int STAT_HALT_BIT = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LOCK_IDLE = 2'b00,
    LOCK_KEY1 = 2'b01,
    LOCK_OPEN = 2'b11
  } osccu_lock_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } osccu_bus_req_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } osccu_pin_t;

  typedef struct packed {
    logic int_precision_osc_enable;
    logic crystal_osc_enable;
    logic watchdog_osc_enable;
    logic sysclk_fail_detect_enable;
    logic watchdog_osc_fail_detect_enable;
    logic [2:0] sysclk_source_select;
  } osccu_ctrl_t;

endpackage

// ==== hdl/osccu_top.sv ====
// Oscillator control register behind a two-byte unlock sequence.
// Assumes an Avalon-MM master with waitrequest, synchronous pins and one clock.
//
// Behaviour
// - Writing E7 then 18 to the control register unlocks it.
// - The next control write after unlocking loads the value and relocks.
// - Control writes outside a completed unlock pair leave contents unchanged.
// - Keys must come in order but other bus cycles may sit between them.
// - Accesses to other registers never cancel a pending unlock.
// - Bit 7 enables the internal precision oscillator; resets to one.
// - Bit 6 enables the crystal oscillator and overrides both crystal pins' port use.
// - Bit 5 enables the watchdog oscillator; resets to one.
// - Bit 4 enables system clock failure detection and recovery; resets to zero.
// - The select field picks the oscillator driving the system clock.
// - All sources and failure detection off halts until power-on reset.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps

module osccu_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [osccu_pkg::ADDR_W-1:0] avs_address,
  input wire logic [osccu_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [osccu_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output osccu_pkg::osccu_ctrl_t osc_ctrl,
  input wire osccu_pkg::osccu_pin_t gpio_pin_a,
  input wire osccu_pkg::osccu_pin_t gpio_pin_b,
  output osccu_pkg::osccu_pin_t crystal_pin_a,
  output osccu_pkg::osccu_pin_t crystal_pin_b,
  output logic sys_halted
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic waitreq;
    logic [osccu_pkg::DATA_W-1:0] rdata;
    osccu_pkg::osccu_lock_t lock;
    logic [7:0] ctrl;
    osccu_pkg::osccu_pin_t pin_a;
    osccu_pkg::osccu_pin_t pin_b;
  } osccu_state_t;

  osccu_state_t s_q;
  osccu_state_t s_d;

  osccu_pkg::osccu_bus_req_t req;
  logic halted;
  logic dead_cfg;
  logic req_live;
  logic accept_wr;
  logic hit_ctrl;
  logic hit_stat;
  logic [7:0] wbyte;

  // One driver for the whole carrier; per-field assigns would multiply drive it
  assign req = '{
    read: avs_read,
    write: avs_write,
    address: avs_address,
    writedata: avs_writedata,
    byteenable: avs_byteenable
  };

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Only byte lane 0 carries the register; upper lanes read zero
  // Only control hits reach the sequencer, so other traffic leaves it alone
  assign hit_ctrl = (req.address == osccu_pkg::OSC_CTRL_ADDR);
  assign hit_stat = (req.address == osccu_pkg::OSC_STAT_ADDR);
  assign req_live = req.read | req.write;
  assign accept_wr = req.write & ~s_q.waitreq & req.byteenable[0];
  assign wbyte = req.writedata[7:0];

  // Every source stopped and nothing left to recover the clock
  assign dead_cfg = ~s_q.ctrl[osccu_pkg::BIT_INT_OSC_EN]
                  & ~s_q.ctrl[osccu_pkg::BIT_XTAL_EN]
                  & ~s_q.ctrl[osccu_pkg::BIT_WDT_OSC_EN]
                  & ~s_q.ctrl[osccu_pkg::BIT_SYS_FAIL_EN];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;

    // One wait cycle, then acknowledge at the next edge
    s_d.waitreq = ~(req_live & s_q.waitreq);
    s_d.rdata = '0;
    if (req.read & s_q.waitreq) begin
      if (hit_ctrl) begin
        s_d.rdata[7:0] = s_q.ctrl;
      end else if (hit_stat) begin
        s_d.rdata[osccu_pkg::STAT_LOCK_LSB +: 2] = s_q.lock;
        s_d.rdata[osccu_pkg::STAT_HALT_BIT] = halted;
      end
    end

    // A halted part executes no further writes
    if (accept_wr & hit_ctrl & ~halted) begin
      unique case (s_q.lock)
        osccu_pkg::LOCK_IDLE: begin
          if (wbyte == osccu_pkg::UNLOCK_KEY_FIRST) begin
            s_d.lock = osccu_pkg::LOCK_KEY1;
          end
        end
        osccu_pkg::LOCK_KEY1: begin
          if (wbyte == osccu_pkg::UNLOCK_KEY_SECOND) begin
            s_d.lock = osccu_pkg::LOCK_OPEN;
          end else if (wbyte == osccu_pkg::UNLOCK_KEY_FIRST) begin
            s_d.lock = osccu_pkg::LOCK_KEY1;
          end else begin
            s_d.lock = osccu_pkg::LOCK_IDLE;
          end
        end
        osccu_pkg::LOCK_OPEN: begin
          s_d.ctrl = wbyte;
          s_d.lock = osccu_pkg::LOCK_IDLE;
        end
        default: begin
          s_d.lock = osccu_pkg::LOCK_IDLE;
        end
      endcase
    end

    // Crystal owns both pins while its enable is set
    if (s_q.ctrl[osccu_pkg::BIT_XTAL_EN]) begin
      s_d.pin_a = '{out: 1'b0, oe_n: 1'b1};
      s_d.pin_b = '{out: 1'b0, oe_n: 1'b1};
    end else begin
      s_d.pin_a = gpio_pin_a;
      s_d.pin_b = gpio_pin_b;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.waitreq <= 1'b1;
      s_q.rdata <= '0;
      s_q.lock <= osccu_pkg::LOCK_IDLE;
      s_q.ctrl <= osccu_pkg::OSC_CTRL_RESET;
      s_q.pin_a <= '{out: 1'b0, oe_n: 1'b1};
      s_q.pin_b <= '{out: 1'b0, oe_n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Halt keeper
  // ----------------------------------------
  osccu_halt_keeper u_halt (
    .clk(clk),
    .por(por),
    .dead_cfg(dead_cfg),
    .halted(halted)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_waitrequest = s_q.waitreq;
  assign avs_readdata = s_q.rdata;
  // Select field passes through; encodings are decoded by the clock mux
  assign osc_ctrl = '{
    int_precision_osc_enable: s_q.ctrl[osccu_pkg::BIT_INT_OSC_EN],
    crystal_osc_enable: s_q.ctrl[osccu_pkg::BIT_XTAL_EN],
    watchdog_osc_enable: s_q.ctrl[osccu_pkg::BIT_WDT_OSC_EN],
    sysclk_fail_detect_enable: s_q.ctrl[osccu_pkg::BIT_SYS_FAIL_EN],
    watchdog_osc_fail_detect_enable: s_q.ctrl[osccu_pkg::BIT_WDT_FAIL_EN],
    sysclk_source_select: s_q.ctrl[osccu_pkg::SEL_MSB:osccu_pkg::SEL_LSB]
  };
  assign crystal_pin_a = s_q.pin_a;
  assign crystal_pin_b = s_q.pin_b;
  assign sys_halted = halted;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_first_key: assert property (
    accept_wr && hit_ctrl && !halted && s_q.lock == osccu_pkg::LOCK_IDLE
    && wbyte == osccu_pkg::UNLOCK_KEY_FIRST |=> s_q.lock == osccu_pkg::LOCK_KEY1)
    else $error("first key did not advance the unlock");

  a_second_key: assert property (
    accept_wr && hit_ctrl && !halted && s_q.lock == osccu_pkg::LOCK_KEY1
    && wbyte == osccu_pkg::UNLOCK_KEY_SECOND |=> s_q.lock == osccu_pkg::LOCK_OPEN)
    else $error("second key did not unlock");

  a_open_load: assert property (
    accept_wr && hit_ctrl && !halted && s_q.lock == osccu_pkg::LOCK_OPEN
    |=> s_q.ctrl == $past(wbyte) && s_q.lock == osccu_pkg::LOCK_IDLE)
    else $error("unlocked write not loaded or not relocked");

  a_locked_keep: assert property (
    s_q.lock != osccu_pkg::LOCK_OPEN |=> $stable(s_q.ctrl))
    else $error("control changed while locked");

  a_other_keep: assert property (
    req_live && !hit_ctrl |=> $stable(s_q.lock))
    else $error("other register access disturbed unlock");

  a_bad_key: assert property (
    accept_wr && hit_ctrl && !halted && s_q.lock == osccu_pkg::LOCK_KEY1
    && wbyte != osccu_pkg::UNLOCK_KEY_SECOND && wbyte != osccu_pkg::UNLOCK_KEY_FIRST
    |=> s_q.lock == osccu_pkg::LOCK_IDLE)
    else $error("wrong key did not restart the unlock");

  a_xtal_pins: assert property (
    osc_ctrl.crystal_osc_enable ##1 osc_ctrl.crystal_osc_enable
    |-> crystal_pin_a.oe_n && crystal_pin_b.oe_n)
    else $error("crystal pins still driven by port");

  // Port side must follow the port wish one cycle late, not only release
  a_port_pins: assert property (
    !osc_ctrl.crystal_osc_enable
    |=> crystal_pin_a == $past(gpio_pin_a) && crystal_pin_b == $past(gpio_pin_b))
    else $error("crystal pins do not follow the port setting");

  a_wait_ack: assert property (
    req_live && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not released for exactly one cycle");

  a_idle_rdata: assert property (
    avs_waitrequest |-> avs_readdata == '0)
    else $error("read data not zero outside the answer cycle");

  a_dead_halt: assert property (
    dead_cfg |=> sys_halted)
    else $error("dead clock setup did not halt");

  a_halt_freeze: assert property (
    sys_halted |=> $stable(s_q.ctrl) && $stable(s_q.lock))
    else $error("halted part still took a control write");

endmodule

// ==== test/osccu_bench.sv ====
// Self-checking bench for the oscillator control unit.
// Assumes osccu_pkg and osccu_top are compiled first; its assertions live in the design.
`timescale 1ns/1ps

module osccu_bench;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst, por, avs_read, avs_write, avs_waitrequest, sys_halted;
  logic [osccu_pkg::ADDR_W-1:0] avs_address;
  logic [osccu_pkg::DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  osccu_pkg::osccu_ctrl_t osc_ctrl;
  osccu_pkg::osccu_pin_t gpio_pin_a, gpio_pin_b, crystal_pin_a, crystal_pin_b;
  logic [7:0] exp_ctrl;
  logic [1:0] exp_lock;
  logic exp_halt;
  int fails, tests_run;

  always #5 clk = ~clk;

  osccu_top osccu_top_i (
    .clk(clk), .rst(rst), .por(por), .avs_read(avs_read), .avs_write(avs_write),
    .avs_address(avs_address), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_ctrl(osc_ctrl), .gpio_pin_a(gpio_pin_a),
    .gpio_pin_b(gpio_pin_b), .crystal_pin_a(crystal_pin_a),
    .crystal_pin_b(crystal_pin_b), .sys_halted(sys_halted)
  );

  // ----------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------
  task tally_and_finish;
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Unlock sequencer as software sees it; repeated first key restarts
  function automatic logic [1:0] lock_next(logic [1:0] s, logic [7:0] d);
    if (s == 2'b01 && d == osccu_pkg::UNLOCK_KEY_SECOND) return 2'b11;
    return (d == osccu_pkg::UNLOCK_KEY_FIRST) ? 2'b01 : 2'b00;
  endfunction

  // Entered just after an edge; trailing edge keeps strobes from double assignment
  // Waits for the answer however long it takes; only the watchdog ends a hang
  task bus(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [31:0] q);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h0000_00, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task ctl_wr(input logic [7:0] d);
    bus(1'b1, osccu_pkg::OSC_CTRL_ADDR, d, rd);
    if (!exp_halt) begin
      if (exp_lock == 2'b11) begin
        exp_ctrl = d;
        exp_lock = 2'b00;
        exp_halt = (d[7:4] == 4'h0);
      end else exp_lock = lock_next(exp_lock, d);
    end
  endtask

  task stat_chk;
    bus(1'b0, osccu_pkg::OSC_STAT_ADDR, 8'h00, rd);
    chk(rd, {29'h0000_0000, exp_halt, exp_lock});
  endtask

  // Pins are checked after the control register and one cycle of pin lag
  task check;
    bus(1'b0, osccu_pkg::OSC_CTRL_ADDR, 8'h00, rd);
    chk(rd, {24'h0000_00, exp_ctrl});
    @(posedge clk);
    chk({24'h0000_00, osc_ctrl}, {24'h0000_00, exp_ctrl});
    chk({30'h0, crystal_pin_a}, exp_ctrl[6] ? 32'h0000_0001 : {30'h0, gpio_pin_a});
    chk({30'h0, crystal_pin_b}, exp_ctrl[6] ? 32'h0000_0001 : {30'h0, gpio_pin_b});
    chk({31'h0, sys_halted}, {31'h0, exp_halt});
  endtask

  task unlock_write(input logic [7:0] d);
    ctl_wr(osccu_pkg::UNLOCK_KEY_FIRST);
    ctl_wr(osccu_pkg::UNLOCK_KEY_SECOND);
    ctl_wr(d);
    check();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    por = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 16'h0000;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    gpio_pin_a = 2'b10;
    gpio_pin_b = 2'b01;
    exp_ctrl = osccu_pkg::OSC_CTRL_RESET;
    exp_lock = 2'b00;
    exp_halt = 1'b0;
    fails = 0;
    tests_run = 0;
    void'($urandom(50));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    check();
    ctl_wr(8'h3C);
    check();
    ctl_wr(osccu_pkg::UNLOCK_KEY_FIRST);
    stat_chk();
    bus(1'b1, 16'h0100, 8'h5A, rd);
    bus(1'b0, 16'h0100, 8'h00, rd);
    chk(rd, 32'h0000_0000);
    ctl_wr(osccu_pkg::UNLOCK_KEY_SECOND);
    stat_chk();
    // Lane 0 disabled: acknowledged but must neither load nor relock
    avs_byteenable <= 4'h0;
    bus(1'b1, osccu_pkg::OSC_CTRL_ADDR, 8'h00, rd);
    avs_byteenable <= 4'h1;
    stat_chk();
    ctl_wr(8'hD5);
    check();
    ctl_wr(8'h80);
    check();
    ctl_wr(8'h18);
    ctl_wr(8'hE7);
    ctl_wr(8'hC1);
    check();
    ctl_wr(8'hE7);
    ctl_wr(8'h55);
    ctl_wr(8'h18);
    ctl_wr(8'hF2);
    check();
    for (int s = 0; s < 8; s++) unlock_write(8'hA0 | 8'(s));
    gpio_pin_a <= 2'b11;
    // Crystal enabled first and left to settle before it is selected
    unlock_write(8'hE0);
    repeat (4) @(posedge clk);
    unlock_write(8'hE3);
    // Random data writes force bit 7 and a loaded 18 keeps bit 4 set, so the loop never halts the clock
    repeat (200) begin
      gpio_pin_a <= 2'($urandom);
      gpio_pin_b <= 2'($urandom);
      case ($urandom_range(0, 4))
        0: ctl_wr(osccu_pkg::UNLOCK_KEY_FIRST);
        1: ctl_wr(osccu_pkg::UNLOCK_KEY_SECOND);
        2: ctl_wr(8'($urandom) | 8'h80);
        3: stat_chk();
        default: bus(1'b1, 16'h0200, 8'($urandom), rd);
      endcase
      check();
    end
    // Random mix may leave the register open; one plain write settles it to idle
    ctl_wr(8'hC0);
    unlock_write(8'h07);
    chk({31'h0, sys_halted}, 32'h0000_0001);
    unlock_write(8'hA0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    exp_ctrl = osccu_pkg::OSC_CTRL_RESET;
    exp_lock = 2'b00;
    @(posedge clk);
    check();
    por <= 1'b1;
    repeat (2) @(posedge clk);
    por <= 1'b0;
    exp_halt = 1'b0;
    @(posedge clk);
    check();
    tally_and_finish();
  end

  // ----------------------------------------
  // Watchdog, about thirty times the expected run
  // ----------------------------------------
  initial begin
    #500_000;
    fails++;
    tally_and_finish();
  end
endmodule
